// ===== srt_params.svh
// Purpose: constants of the status reporting tree
// Assumes: included by every file that needs offsets, resets or bit positions
// Notes: definitions only
`ifndef SRT_PARAMS_SVH
`define SRT_PARAMS_SVH

// ----------------------------------------
// scpi register parts
// ----------------------------------------
`define SRT_SCPI_WIDTH 16
`define SRT_SCPI_VALID_MASK 16'h7FFF
`define SRT_COND_RST 16'h0000
`define SRT_PTR_RST 16'h7FFF
`define SRT_NTR_RST 16'h0000
`define SRT_EVT_RST 16'h0000
`define SRT_ENA_RST 16'h0000

// ----------------------------------------
// event status register
// ----------------------------------------
`define SRT_ESR_RST 8'h80
`define SRT_ESR_VALID_MASK 8'hFD
`define SRT_ESE_RST 8'h00
`define SRT_ESR_OPC_BIT 0
`define SRT_ESR_QYE_BIT 2
`define SRT_ESR_DDE_BIT 3
`define SRT_ESR_EXE_BIT 4
`define SRT_ESR_CME_BIT 5
`define SRT_ESR_URQ_BIT 6

// ----------------------------------------
// status byte and its masks
// ----------------------------------------
`define SRT_SRE_RST 8'h00
`define SRT_SRE_VALID_MASK 8'hBF
`define SRT_PPE_RST 8'h00
`define SRT_STB_ERRQ_BIT 2
`define SRT_STB_QUES_BIT 3
`define SRT_STB_MAV_BIT 4
`define SRT_STB_ESB_BIT 5
`define SRT_STB_MSS_BIT 6
`define SRT_STB_OPER_BIT 7

`endif

// ===== srt_pkg.sv
// Purpose: types of the status reporting tree
// Assumes: nothing
// Notes: command unit and part selects of the remote command port
package srt_pkg;

  // ----------------------------------------
  // command target unit
  // ----------------------------------------
  typedef enum logic [1:0] {
    SRT_UNIT_COMMON = 2'h0,
    SRT_UNIT_OPER = 2'h1,
    SRT_UNIT_QUES = 2'h2
  } srt_unit_t;

  // ----------------------------------------
  // common command parts
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRT_CMN_STB = 3'h0,
    SRT_CMN_SRE = 3'h1,
    SRT_CMN_PPE = 3'h2,
    SRT_CMN_ESR = 3'h3,
    SRT_CMN_ESE = 3'h4,
    SRT_CMN_IST = 3'h5
  } srt_cmn_part_t;

  // ----------------------------------------
  // scpi register parts
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRT_PART_COND = 3'h0,
    SRT_PART_EVENT = 3'h1,
    SRT_PART_PTR = 3'h2,
    SRT_PART_NTR = 3'h3,
    SRT_PART_ENABLE = 3'h4
  } srt_scpi_part_t;

endpackage

// ===== srt_scpi_reg.sv
// Purpose: one five-part scpi status register with summary
// Assumes: condition inputs come from logic on clk_i
// Notes: top bit of every part is held at zero
`timescale 1ns/1ps
`include "srt_params.svh"

module srt_scpi_reg #(
  parameter int WIDTH = `SRT_SCPI_WIDTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // live condition
  input wire logic [WIDTH-1:0] cond_i,
  // access
  input wire logic sel_i,
  input wire logic wr_i,
  input wire srt_pkg::srt_scpi_part_t part_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic summary_o
);

  localparam logic [WIDTH-1:0] VALID = `SRT_SCPI_VALID_MASK;

  if (WIDTH != 16) begin : g_chk
    $error("srt_scpi_reg: WIDTH must be 16");
  end

  logic [WIDTH-1:0] cond_reg, ptr_reg, ntr_reg, event_reg, enable_reg;
  logic [WIDTH-1:0] cond_next, ptr_next, ntr_next, event_next, enable_next;
  logic [WIDTH-1:0] rise, fall;
  logic wr_ptr, wr_ntr, wr_ena, rd_event;

  // ----------------------------------------
  // access strobes
  // ----------------------------------------
  assign wr_ptr = sel_i && wr_i && (part_i == srt_pkg::SRT_PART_PTR);
  assign wr_ntr = sel_i && wr_i && (part_i == srt_pkg::SRT_PART_NTR);
  assign wr_ena = sel_i && wr_i && (part_i == srt_pkg::SRT_PART_ENABLE);
  assign rd_event = sel_i && !wr_i && (part_i == srt_pkg::SRT_PART_EVENT);

  // ----------------------------------------
  // next values
  // ----------------------------------------
  assign cond_next = cond_i & VALID; // see (R3) see (R2)
  assign rise = cond_next & ~cond_reg & ptr_reg; // see (R4)
  assign fall = ~cond_next & cond_reg & ntr_reg; // see (R5)
  // set wins over read clear
  assign event_next = ((rd_event ? '0 : event_reg) | rise | fall) & VALID; // see (R7)
  assign ptr_next = wr_ptr ? (wdata_i & VALID) : ptr_reg; // see (R6)
  assign ntr_next = wr_ntr ? (wdata_i & VALID) : ntr_reg; // see (R6)
  assign enable_next = wr_ena ? (wdata_i & VALID) : enable_reg; // see (R9)

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_reg <= `SRT_COND_RST;
      ptr_reg <= `SRT_PTR_RST;
      ntr_reg <= `SRT_NTR_RST;
      event_reg <= `SRT_EVT_RST;
      enable_reg <= `SRT_ENA_RST;
    end else begin
      cond_reg <= cond_next;
      ptr_reg <= ptr_next;
      ntr_reg <= ntr_next;
      event_reg <= event_next;
      enable_reg <= enable_next;
    end
  end

  // ----------------------------------------
  // read data and summary
  // ----------------------------------------
  always_comb begin
    if (part_i == srt_pkg::SRT_PART_COND) begin
      rdata_o = cond_reg;
    end else if (part_i == srt_pkg::SRT_PART_EVENT) begin
      rdata_o = event_reg;
    end else if (part_i == srt_pkg::SRT_PART_PTR) begin
      rdata_o = ptr_reg;
    end else if (part_i == srt_pkg::SRT_PART_NTR) begin
      rdata_o = ntr_reg;
    end else if (part_i == srt_pkg::SRT_PART_ENABLE) begin
      rdata_o = enable_reg;
    end else begin
      rdata_o = '0;
    end
  end

  assign summary_o = |(event_reg & enable_reg); // see (R8)

endmodule // srt_scpi_reg

// ===== srt_event_status.sv
// Purpose: event status register with its enable mask
// Assumes: event inputs are one-cycle pulses on clk_i
// Notes: power-on bit is set by reset itself
`timescale 1ns/1ps
`include "srt_params.svh"

module srt_event_status (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // events
  input wire logic [7:0] event_i,
  // access
  input wire logic rd_clr_i,
  input wire logic ese_wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] esr_o,
  output logic [7:0] ese_o,
  output logic summary_o
);

  logic [7:0] esr_reg, ese_reg;
  logic [7:0] esr_next, ese_next;

  // ----------------------------------------
  // latch and enable
  // ----------------------------------------
  // set wins over read clear; bit 1 stays zero
  assign esr_next = ((rd_clr_i ? 8'h00 : esr_reg) | event_i) & `SRT_ESR_VALID_MASK; // see (R21)
  assign ese_next = ese_wr_i ? wdata_i : ese_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      esr_reg <= `SRT_ESR_RST; // see (R21)
      ese_reg <= `SRT_ESE_RST;
    end else begin
      esr_reg <= esr_next;
      ese_reg <= ese_next;
    end
  end

  assign esr_o = esr_reg;
  assign ese_o = ese_reg;
  assign summary_o = |(esr_reg & ese_reg); // see (R16)

endmodule // srt_event_status

// ===== srt_status_tree.sv
// Purpose: status byte, service request and parallel poll flag of an instrument
// Assumes: all status inputs come from logic on clk_i; one command per cycle at most
// Notes: command port stands for the common and status commands of the remote interface
`timescale 1ns/1ps
`include "srt_params.svh"

// How it works
// (R1) each scpi register has five 16-bit parts sharing bit positions
// (R2) bit 15 of every scpi part always reads zero
// (R3) condition part mirrors live inputs, ignores writes, read changes nothing
// (R4) rising condition bit sets event bit only where rising filter is one
// (R5) falling condition bit sets event bit only where falling filter is one
// (R6) both filters are read-write and reading keeps them
// (R7) event bits latch transitions, set by logic only, cleared after read
// (R8) summary is the or of event bits anded with enable bits
// (R9) enable part is read-write and reading clears nothing
// (R10) each summary feeds a condition bit of the next level up
// (R11) status byte bit 6 is the master summary of the others
// (R12) service request mask ignores bit 6; enabled rising bit raises request
// (R13) status byte bits 0 and 1 read zero; bit 2 means errors queued
// (R14) status byte bit 3 is the questionable register summary
// (R15) status byte bit 4 shows response data waiting in output buffer
// (R16) status byte bit 5 is masked event status summary
// (R17) status byte bit 7 is the operation register summary
// (R18) individual status flag is or of status byte bits anded with parallel poll mask
// (R19) controller polls completion with event enable bit 0 and status queries
// (R20) controller restores its timeout and clears the interrupted-query error; poll_done restores wait_lim but sends no clear of its own
// (R21) event status bit 0 operation complete, 5 command error, 7 power-on
// (R22) summaries are combinational from registered state, visible next cycle
module srt_status_tree #(
  parameter int WIDTH = `SRT_SCPI_WIDTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // scpi condition inputs
  input wire logic [WIDTH-1:0] oper_cond_i,
  input wire logic [WIDTH-1:0] ques_cond_i,
  // event status pulses
  input wire logic op_complete_i,
  input wire logic query_error_i,
  input wire logic device_error_i,
  input wire logic exec_error_i,
  input wire logic cmd_error_i,
  input wire logic user_request_i,
  // queue levels
  input wire logic err_queue_busy_i,
  input wire logic msg_avail_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire srt_pkg::srt_unit_t cmd_unit_i,
  input wire logic [2:0] cmd_part_i,
  input wire logic [WIDTH-1:0] cmd_wdata_i,
  // response
  output logic rsp_valid_o,
  output logic [WIDTH-1:0] rsp_data_o,
  // status outputs
  output logic [7:0] stb_o,
  output logic srq_o,
  output logic ist_o
);

  if (WIDTH != 16) begin : g_chk
    $error("srt_status_tree: WIDTH must be 16");
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0] sre_reg, sre_next;
  logic [7:0] ppe_reg, ppe_next;
  logic [7:0] srq_arm_reg;
  logic srq_reg, srq_next;
  logic [7:0] stb_reg;
  logic ist_reg;
  logic rsp_valid_reg;
  logic [WIDTH-1:0] rsp_data_reg, rsp_data_next;

  logic sel_common, sel_oper, sel_ques;
  logic rd_common;
  srt_pkg::srt_cmn_part_t cmn_part;
  srt_pkg::srt_scpi_part_t scpi_part;
  logic wr_sre, wr_ppe, wr_ese, rd_esr;

  logic [WIDTH-1:0] oper_rdata, ques_rdata;
  logic oper_sum, ques_sum;
  logic [7:0] esr_val, ese_val, esr_events;
  logic esb_sum;

  logic [7:0] stb_base, stb_full, srq_cand;
  logic mss, srq_rise, ist_now;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign cmn_part = srt_pkg::srt_cmn_part_t'(cmd_part_i);
  assign scpi_part = srt_pkg::srt_scpi_part_t'(cmd_part_i);
  assign sel_common = cmd_valid_i && (cmd_unit_i == srt_pkg::SRT_UNIT_COMMON);
  assign sel_oper = cmd_valid_i && (cmd_unit_i == srt_pkg::SRT_UNIT_OPER);
  assign sel_ques = cmd_valid_i && (cmd_unit_i == srt_pkg::SRT_UNIT_QUES);
  assign rd_common = sel_common && !cmd_write_i;
  assign wr_sre = sel_common && cmd_write_i && (cmn_part == srt_pkg::SRT_CMN_SRE);
  assign wr_ppe = sel_common && cmd_write_i && (cmn_part == srt_pkg::SRT_CMN_PPE);
  assign wr_ese = sel_common && cmd_write_i && (cmn_part == srt_pkg::SRT_CMN_ESE);
  assign rd_esr = rd_common && (cmn_part == srt_pkg::SRT_CMN_ESR);

  // ----------------------------------------
  // scpi status registers
  // ----------------------------------------
  // see (R1)
  srt_scpi_reg #(
    .WIDTH(WIDTH)
  ) u_oper (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(oper_cond_i),
    .sel_i(sel_oper),
    .wr_i(cmd_write_i),
    .part_i(scpi_part),
    .wdata_i(cmd_wdata_i),
    .rdata_o(oper_rdata),
    .summary_o(oper_sum)
  );

  srt_scpi_reg #(
    .WIDTH(WIDTH)
  ) u_ques (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(ques_cond_i),
    .sel_i(sel_ques),
    .wr_i(cmd_write_i),
    .part_i(scpi_part),
    .wdata_i(cmd_wdata_i),
    .rdata_o(ques_rdata),
    .summary_o(ques_sum)
  );

  // ----------------------------------------
  // event status register
  // ----------------------------------------
  always_comb begin
    esr_events = 8'h00;
    esr_events[`SRT_ESR_OPC_BIT] = op_complete_i; // see (R21)
    esr_events[`SRT_ESR_QYE_BIT] = query_error_i;
    esr_events[`SRT_ESR_DDE_BIT] = device_error_i;
    esr_events[`SRT_ESR_EXE_BIT] = exec_error_i;
    esr_events[`SRT_ESR_CME_BIT] = cmd_error_i; // see (R21)
    esr_events[`SRT_ESR_URQ_BIT] = user_request_i;
  end

  srt_event_status u_esr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(esr_events),
    .rd_clr_i(rd_esr),
    .ese_wr_i(wr_ese),
    .wdata_i(cmd_wdata_i[7:0]),
    .esr_o(esr_val),
    .ese_o(ese_val),
    .summary_o(esb_sum)
  );

  // ----------------------------------------
  // status byte assembly
  // ----------------------------------------
  // summaries climb into the status byte as its condition bits
  always_comb begin
    stb_base = 8'h00; // see (R13)
    stb_base[`SRT_STB_ERRQ_BIT] = err_queue_busy_i; // see (R13)
    stb_base[`SRT_STB_QUES_BIT] = ques_sum; // see (R14) see (R10)
    stb_base[`SRT_STB_MAV_BIT] = msg_avail_i; // see (R15)
    stb_base[`SRT_STB_ESB_BIT] = esb_sum; // see (R16) see (R10)
    stb_base[`SRT_STB_OPER_BIT] = oper_sum; // see (R17) see (R10)
  end

  // request candidates exclude bit 6 by the mask itself
  assign srq_cand = stb_base & sre_reg; // see (R12)
  assign mss = |srq_cand; // see (R11) see (R22)
  assign stb_full = stb_base | ({7'h00, mss} << `SRT_STB_MSS_BIT); // see (R11)
  assign srq_rise = |(srq_cand & ~srq_arm_reg); // see (R12)
  // set wins; request drops once no enabled bit remains
  assign srq_next = srq_rise || (srq_reg && mss); // see (R11)
  assign ist_now = |(stb_full & ppe_reg); // see (R18) see (R22)

  // ----------------------------------------
  // mask registers
  // ----------------------------------------
  assign sre_next = wr_sre ? (cmd_wdata_i[7:0] & `SRT_SRE_VALID_MASK) : sre_reg; // see (R12)
  assign ppe_next = wr_ppe ? cmd_wdata_i[7:0] : ppe_reg; // see (R18)

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sre_reg <= `SRT_SRE_RST;
      ppe_reg <= `SRT_PPE_RST;
    end else begin
      sre_reg <= sre_next;
      ppe_reg <= ppe_next;
    end
  end

  // ----------------------------------------
  // service request and flags
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srq_arm_reg <= 8'h00;
      srq_reg <= 1'b0;
      stb_reg <= 8'h00;
      ist_reg <= 1'b0;
    end else begin
      srq_arm_reg <= srq_cand;
      srq_reg <= srq_next;
      stb_reg <= stb_full;
      ist_reg <= ist_now;
    end
  end

  // ----------------------------------------
  // response mux
  // ----------------------------------------
  always_comb begin
    rsp_data_next = '0;
    if (cmd_write_i) begin
      rsp_data_next = '0;
    end else if (sel_oper) begin
      rsp_data_next = oper_rdata;
    end else if (sel_ques) begin
      rsp_data_next = ques_rdata;
    end else if (rd_common && cmn_part == srt_pkg::SRT_CMN_STB) begin
      rsp_data_next = {8'h00, stb_full};
    end else if (rd_common && cmn_part == srt_pkg::SRT_CMN_SRE) begin
      rsp_data_next = {8'h00, sre_reg};
    end else if (rd_common && cmn_part == srt_pkg::SRT_CMN_PPE) begin
      rsp_data_next = {8'h00, ppe_reg};
    end else if (rd_esr) begin
      rsp_data_next = {8'h00, esr_val}; // see (R7)
    end else if (rd_common && cmn_part == srt_pkg::SRT_CMN_ESE) begin
      rsp_data_next = {8'h00, ese_val};
    end else if (rd_common && cmn_part == srt_pkg::SRT_CMN_IST) begin
      rsp_data_next = {15'h0000, ist_now};
    end else begin
      rsp_data_next = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
    end else begin
      rsp_valid_reg <= cmd_valid_i;
      rsp_data_reg <= rsp_data_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_data_o = rsp_data_reg;
  assign stb_o = stb_reg;
  assign srq_o = srq_reg;
  assign ist_o = ist_reg;

endmodule // srt_status_tree

// ===== srt_status_tree_sva.sv
// Purpose: port assertions of the status tree
// Assumes: one clock domain, sync reset
// Notes: bound to srt_status_tree below
`timescale 1ns/1ps
module srt_status_tree_sva #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // status inputs
  input wire logic [WIDTH-1:0] oper_cond_i,
  input wire logic err_queue_busy_i,
  input wire logic msg_avail_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire srt_pkg::srt_unit_t cmd_unit_i,
  input wire logic [2:0] cmd_part_i,
  // outputs
  input wire logic rsp_valid_o,
  input wire logic [WIDTH-1:0] rsp_data_o,
  input wire logic [7:0] stb_o,
  input wire logic srq_o,
  input wire logic ist_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // operation register queries and command responses
  // ----------------------------------------
  sequence s_oper_rd(p);
    cmd_valid_i && !cmd_write_i && cmd_unit_i == srt_pkg::SRT_UNIT_OPER && cmd_part_i == p;
  endsequence
  sequence s_quiet;
    !$past(rst_i) && $stable(oper_cond_i) ##1 $stable(oper_cond_i);
  endsequence
  AST_EVT_CLEARED: assert property (s_oper_rd(3'h1) ##0 s_quiet ##1 s_oper_rd(3'h1) |=> rsp_data_o == 16'h0000)
    else $error("event part not cleared by read");
  AST_COND_MIRROR: assert property (s_oper_rd(3'h0) ##0 !$past(rst_i) |=> rsp_data_o == ($past(oper_cond_i, 2) & 16'h7FFF))
    else $error("condition part differs from inputs");
  AST_WRITE_ANSWER: assert property (cmd_valid_i && cmd_write_i |=> rsp_valid_o && rsp_data_o == 16'h0000)
    else $error("write not answered with zero");
  AST_TOP_BIT_ZERO: assert property (rsp_valid_o |-> !rsp_data_o[WIDTH-1])
    else $error("top bit of a part reads one");
  // ----------------------------------------
  // status byte
  // ----------------------------------------
  AST_LOW_BITS_ZERO: assert property (stb_o[1:0] == 2'b00)
    else $error("unused status bits set");
  AST_ERRQ_BIT: assert property (err_queue_busy_i [*3] |-> stb_o[2])
    else $error("error queue bit missing");
  AST_MAV_BIT: assert property (!msg_avail_i [*3] |-> !stb_o[4])
    else $error("message bit set without data");
  AST_MSS_SUM: assert property (stb_o[6] |-> (|{stb_o[7], stb_o[5:2]}))
    else $error("master summary without source");
  AST_SRQ_MSS: assert property ($rose(srq_o) |-> ##[0:1] stb_o[6])
    else $error("service request without master summary");
  AST_IST_SRC: assert property (ist_o |-> stb_o != 8'h00)
    else $error("status flag without status byte bit");
endmodule // srt_status_tree_sva

bind srt_status_tree srt_status_tree_sva #(.WIDTH(WIDTH)) u_sva (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .oper_cond_i(oper_cond_i),
  .err_queue_busy_i(err_queue_busy_i),
  .msg_avail_i(msg_avail_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_write_i(cmd_write_i),
  .cmd_unit_i(cmd_unit_i),
  .cmd_part_i(cmd_part_i),
  .rsp_valid_o(rsp_valid_o),
  .rsp_data_o(rsp_data_o),
  .stb_o(stb_o),
  .srq_o(srq_o),
  .ist_o(ist_o)
);

// ===== srt_ctrl_model.sv
// Purpose: remote controller issuing status commands
// Assumes: one command per call, changes 1 ns after an edge
// Notes: idle lines carry the inverse of the last command
`timescale 1ns/1ps
module srt_ctrl_model (
  // clock
  input wire logic clk_i,
  // response
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_data_i,
  // command
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output srt_pkg::srt_unit_t cmd_unit_o,
  output logic [2:0] cmd_part_o,
  output logic [15:0] cmd_wdata_o
);
  int wait_lim = 4;
  logic rsp_ok;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b1;
    cmd_unit_o = srt_pkg::SRT_UNIT_QUES;
    cmd_part_o = 3'h7;
    cmd_wdata_o = 16'hFFFF;
  end
  task send(input logic [1:0] unit, input logic [2:0] part, input logic wr, input logic [15:0] wd,
            output logic [15:0] rd);
    @(posedge clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_unit_o = srt_pkg::srt_unit_t'(unit);
    cmd_part_o = part;
    cmd_wdata_o = wd;
    @(posedge clk_i);
    #1;
    rsp_ok = rsp_valid_i;
    rd = rsp_valid_i ? rsp_data_i : 16'hDEAD;
    cmd_valid_o = 1'b0;
    cmd_write_o = ~wr;
    cmd_unit_o = srt_pkg::srt_unit_t'(~unit);
    cmd_part_o = ~part;
    cmd_wdata_o = ~wd;
  endtask
  // completion poll under a short wait, wait restored after
  task poll_done(output logic done);
    int saved;
    logic [15:0] rd;
    saved = wait_lim;
    wait_lim = 1;
    send(2'h0, 3'h3, 1'b0, 16'h0000, rd);
    done = rd[0];
    wait_lim = saved;
  endtask
endmodule // srt_ctrl_model

// ===== srt_status_tree_tb.sv
// Purpose: self-checking bench of the status tree
// Assumes: controller model drives the command port
// Notes: ordinary register accesses run from a table
`timescale 1ns/1ps
module srt_status_tree_tb;
  typedef struct {logic [1:0] unit; logic [2:0] part; logic [15:0] wd; logic [15:0] exp;} srt_row_t;
  logic clk_i, rst_i, err_queue_busy_i, msg_avail_i, cmd_valid_i, cmd_write_i, rsp_valid_o, srq_o, ist_o;
  logic op_complete_i, query_error_i, device_error_i, exec_error_i, cmd_error_i, user_request_i, done;
  logic [15:0] oper_cond_i, ques_cond_i, cmd_wdata_i, rsp_data_o, rd;
  logic [2:0] cmd_part_i;
  logic [7:0] stb_o;
  srt_pkg::srt_unit_t cmd_unit_i;
  int bad_count = 0;
  int compares = 0;
  srt_row_t rows[11] = '{
    '{2'h0, 3'h1, 16'hFFFF, 16'h00BF}, '{2'h0, 3'h2, 16'hFFFF, 16'h00FF}, '{2'h0, 3'h4, 16'hFFFF, 16'h00FF},
    '{2'h1, 3'h2, 16'h8005, 16'h0005}, '{2'h1, 3'h3, 16'h8006, 16'h0006}, '{2'h1, 3'h4, 16'h8001, 16'h0001},
    '{2'h1, 3'h0, 16'hFFFF, 16'h0000}, '{2'h1, 3'h1, 16'hFFFF, 16'h0000}, '{2'h2, 3'h2, 16'h1234, 16'h1234},
    '{2'h2, 3'h4, 16'hFFFF, 16'h7FFF}, '{2'h0, 3'h0, 16'hFFFF, 16'h0000}};
  srt_status_tree #(.WIDTH(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .oper_cond_i(oper_cond_i),
    .ques_cond_i(ques_cond_i), .op_complete_i(op_complete_i), .query_error_i(query_error_i),
    .device_error_i(device_error_i), .exec_error_i(exec_error_i), .cmd_error_i(cmd_error_i),
    .user_request_i(user_request_i), .err_queue_busy_i(err_queue_busy_i), .msg_avail_i(msg_avail_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_unit_i(cmd_unit_i), .cmd_part_i(cmd_part_i),
    .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .stb_o(stb_o),
    .srq_o(srq_o), .ist_o(ist_o));
  srt_ctrl_model ctl (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
    .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i), .cmd_unit_o(cmd_unit_i), .cmd_part_o(cmd_part_i),
    .cmd_wdata_o(cmd_wdata_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task stat(input logic [7:0] s, input logic q, input logic i, input string what);
    repeat (3) @(posedge clk_i);
    #1;
    chk({6'h00, stb_o, srq_o, ist_o}, {6'h00, s, q, i}, what);
  endtask
  task pulse(input logic [5:0] v);
    @(posedge clk_i);
    #1;
    {user_request_i, cmd_error_i, exec_error_i, device_error_i, query_error_i, op_complete_i} = v;
    @(posedge clk_i);
    #1;
    {user_request_i, cmd_error_i, exec_error_i, device_error_i, query_error_i, op_complete_i} = 6'h00;
  endtask
  task complete_run();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {rst_i, err_queue_busy_i, msg_avail_i, oper_cond_i, ques_cond_i} = {3'b100, 16'h0000, 16'h0000};
    {user_request_i, cmd_error_i, exec_error_i, device_error_i, query_error_i, op_complete_i} = 6'h00;
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    ctl.send(2'h0, 3'h3, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0080, "power-on event");
    ctl.send(2'h0, 3'h3, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0000, "event status after read");
    ctl.send(2'h1, 3'h2, 1'b0, 16'h0000, rd);
    chk(rd, 16'h7FFF, "rising filter reset");
    chk({8'h00, stb_o}, 16'h0000, "status byte reset");
    $display("test reset done");
    foreach (rows[n]) begin
      ctl.send(rows[n].unit, rows[n].part, 1'b1, rows[n].wd, rd);
      repeat (2) begin
        ctl.send(rows[n].unit, rows[n].part, 1'b0, 16'h0000, rd);
        chk(rd, rows[n].exp, "register readback");
      end
    end
    $display("test registers done");
    oper_cond_i = 16'hFFFF;
    stat(8'hC0, 1'b1, 1'b1, "operation summary");
    ctl.send(2'h1, 3'h0, 1'b0, 16'h0000, rd);
    chk(rd, 16'h7FFF, "condition mirror");
    ctl.send(2'h1, 3'h1, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0005, "rising events");
    ctl.send(2'h1, 3'h1, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0000, "event cleared");
    stat(8'h00, 1'b0, 1'b0, "summary after clear");
    oper_cond_i = 16'h0000;
    stat(8'h00, 1'b0, 1'b0, "masked falling events");
    ctl.send(2'h1, 3'h1, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0006, "falling events");
    ques_cond_i = 16'h0005;
    stat(8'h48, 1'b1, 1'b1, "questionable summary");
    ctl.send(2'h2, 3'h1, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0004, "questionable events");
    $display("test transitions done");
    for (int b = 0; b < 6; b++) pulse(6'h01 << b);
    stat(8'h60, 1'b1, 1'b1, "event status summary");
    ctl.send(2'h0, 3'h3, 1'b0, 16'h0000, rd);
    chk(rd, 16'h007D, "event status bits");
    $display("test event status done");
    err_queue_busy_i = 1'b1;
    msg_avail_i = 1'b1;
    stat(8'h54, 1'b1, 1'b1, "queue levels");
    ctl.send(2'h0, 3'h2, 1'b1, 16'h0040, rd);
    stat(8'h54, 1'b1, 1'b1, "poll flag from bit 6");
    ctl.send(2'h0, 3'h5, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0001, "status flag query");
    chk({15'h0000, ctl.rsp_ok}, 16'h0001, "query answered");
    ctl.send(2'h0, 3'h0, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0054, "status byte query");
    ctl.send(2'h3, 3'h0, 1'b0, 16'h0000, rd);
    chk(rd, 16'h0000, "unmapped unit query");
    ctl.send(2'h0, 3'h1, 1'b1, 16'h0040, rd);
    stat(8'h14, 1'b0, 1'b0, "service mask ignores bit 6");
    err_queue_busy_i = 1'b0;
    msg_avail_i = 1'b0;
    $display("test levels done");
    ctl.send(2'h0, 3'h4, 1'b1, 16'h0001, rd);
    pulse(6'h01);
    ctl.poll_done(done);
    chk({15'h0000, done}, 16'h0001, "completion seen");
    ctl.poll_done(done);
    chk({15'h0000, done}, 16'h0000, "completion cleared");
    $display("test polling done");
    complete_run();
  end
endmodule // srt_status_tree_tb
